// [common/ssc_consts.svh]
// Purpose: offsets, fields, resets and counts of the sweep/sequence port
// Assumes: 32-bit register port, word-aligned byte addresses
// Notes:   definitions only
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
// ****************************************
// Register offsets
// ****************************************
`define SSC_OFS_CTRL      8'h00
`define SSC_OFS_SWEEP_END 8'h04
`define SSC_OFS_SEQ_LAST  8'h08
`define SSC_OFS_STEP_WR   8'h0C
`define SSC_OFS_STATUS    8'h10
// ****************************************
// Field positions
// ****************************************
`define SSC_CTRL_MODE     0
`define SSC_CTRL_IN_EN    1
`define SSC_CTRL_BRANCH   2
`define SSC_CTRL_TRIG_POL 3
`define SSC_STEP_DUR_LSB  0
`define SSC_STEP_DEST_LSB 16
`define SSC_STEP_CODE_LSB 20
`define SSC_STEP_IDX_LSB  24
`define SSC_STAT_STEP_LSB 4
`define SSC_STAT_POS_LSB  16
// ****************************************
// Reset values and timing
// ****************************************
`define SSC_CTRL_RST      4'h0
`define SSC_SWEEP_END_RST 16'hFFFF
`define SSC_SEQ_LAST_RST  4'hF
`define SSC_TICK_NS       1000
`define SSC_CLK_NS        10
`define SSC_TICK_CYC      (`SSC_TICK_NS / `SSC_CLK_NS)
`endif

// [common/ssc_pkg.sv]
// Purpose: types of the sweep/sequence control port
// Assumes: nothing beyond the constants header
// Notes:   one step entry holds code, destination and dwell
package ssc_pkg;
    typedef enum logic [1:0] {
        SSC_IDLE = 2'b00,
        SSC_LOAD = 2'b01,
        SSC_RUN  = 2'b10,
        SSC_HOLD = 2'b11
    } ssc_state_t;
    typedef struct packed {
        logic [3:0]  code;
        logic [3:0]  dest;
        logic [15:0] dur;
    } ssc_step_t;
endpackage

// [common/ssc_mem_if.sv]
// Purpose: step table access between control and memory
// Assumes: one clock, registered read data
// Notes:   write and read ports are independent
`timescale 1ns/1ps
interface ssc_mem_if;
    import ssc_pkg::*;
    logic       wr_en;
    logic [3:0] wr_addr;
    ssc_step_t  wr_data;
    logic [3:0] rd_addr;
    ssc_step_t  rd_data;
    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                 input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data);
endinterface

// [design/ssc_step_mem.sv]
// Purpose: per-step table of code, branch destination and dwell
// Assumes: read data valid the cycle after the address
// Notes:   contents undefined until software writes them
`timescale 1ns/1ps
module ssc_step_mem (
    input  wire logic clk,
    ssc_mem_if.mem    port
);
    import ssc_pkg::*;
    ssc_step_t mem_r [16];
    // ****************************************
    // Storage
    // ****************************************
    // Write port; no reset so it maps onto RAM
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            mem_r[port.wr_addr] <= port.wr_data;
        end
    end
    // Registered read
    always_ff @(posedge clk) begin
        port.rd_data <= mem_r[port.rd_addr];
    end
endmodule

// [design/ssc_top.sv]
// Purpose: control-port logic for sweep and step sequence
// Assumes: connector inputs asynchronous, pulled up, active low except the trigger when the polarity bit is set
// Notes:   sweep position and step advance on a divided tick
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_top #(
    parameter int TICK_CYC = `SSC_TICK_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        start_branch_n,
    input  wire logic        stop_n,
    input  wire logic        hold_resume_n,
    input  wire logic        event_branch_n,
    input  wire logic        trigger_input_terminal,
    output logic             step_code_bit0,
    output logic             step_code_bit1,
    output logic             step_code_bit2,
    output logic             step_code_bit3,
    output logic [15:0]      sweep_pos,
    output ssc_pkg::ssc_state_t run_state
);
    import ssc_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_bad_tick
        $error("TICK_CYC must be 1..65535");
    end

    // ****************************************
    // Declarations
    // ****************************************
    logic [3:0]  ctrl_r;
    logic [15:0] sweep_end_r;
    logic [3:0]  seq_last_r;
    logic [4:0]  pin_raw;
    logic [4:0]  sync1_r;
    logic [4:0]  sync2_r;
    logic [4:0]  prev_r;
    logic [15:0] div_r;
    logic        tick;
    logic        seq_mode;
    logic        in_en;
    logic        branch_sel;
    logic        trig_act;
    logic        start_lvl;
    logic        start_prev;
    logic        start_fall;
    logic        stop_fall;
    logic        hold_fall;
    logic        hold_rise;
    logic        event_fall;
    logic        shared_low;
    ssc_state_t  state_r;
    logic [3:0]  step_r;
    logic [15:0] dwell_r;
    logic [15:0] pos_r;
    logic        wait_r;
    logic [3:0]  code_r;
    ssc_mem_if   mem_port ();

    assign seq_mode   = ctrl_r[`SSC_CTRL_MODE];
    assign in_en      = ctrl_r[`SSC_CTRL_IN_EN];
    assign branch_sel = ctrl_r[`SSC_CTRL_BRANCH];

    // ****************************************
    // Register port
    // ****************************************
    // Control fields steer the sequencer directly
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `SSC_CTRL_RST;
        end else if (reg_wr && reg_addr == `SSC_OFS_CTRL) begin
            ctrl_r <= reg_wdata[3:0];
        end
    end

    // Sweep end point and last sequence step
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sweep_end_r <= `SSC_SWEEP_END_RST;
            seq_last_r  <= `SSC_SEQ_LAST_RST;
        end else if (reg_wr) begin
            if (reg_addr == `SSC_OFS_SWEEP_END) begin
                sweep_end_r <= reg_wdata[15:0];
            end
            if (reg_addr == `SSC_OFS_SEQ_LAST) begin
                seq_last_r <= reg_wdata[3:0];
            end
        end
    end

    // Step table writes go straight to memory, no storage here
    assign mem_port.wr_en   = reg_wr && reg_addr == `SSC_OFS_STEP_WR;
    assign mem_port.wr_addr = reg_wdata[`SSC_STEP_IDX_LSB +: 4];
    assign mem_port.wr_data = '{code: reg_wdata[`SSC_STEP_CODE_LSB +: 4],
                                dest: reg_wdata[`SSC_STEP_DEST_LSB +: 4],
                                dur:  reg_wdata[`SSC_STEP_DUR_LSB +: 16]};

    // Read data stand one cycle only; unmapped reads give zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            unique case (reg_addr)
                `SSC_OFS_CTRL:      reg_rdata <= {28'h0, ctrl_r};
                `SSC_OFS_SWEEP_END: reg_rdata <= {16'h0, sweep_end_r};
                `SSC_OFS_SEQ_LAST:  reg_rdata <= {28'h0, seq_last_r};
                `SSC_OFS_STATUS: begin
                    reg_rdata <= {pos_r, 8'h0, step_r, 2'h0, state_r};
                end
                default:            reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Input synchronisers and edges
    // ****************************************
    // Bit order: 0 start/branch, 1 stop, 2 hold, 3 event, 4 trigger
    assign pin_raw = {trigger_input_terminal, event_branch_n, hold_resume_n,
                      stop_n, start_branch_n};

    // Two flops per pin, then one more sample for edges; idle high
    for (genvar i = 0; i < 5; i++) begin : g_sync
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                sync1_r[i] <= 1'b1;
                sync2_r[i] <= 1'b1;
                prev_r[i]  <= 1'b1;
            end else begin
                sync1_r[i] <= pin_raw[i];
                sync2_r[i] <= sync1_r[i];
                prev_r[i]  <= sync2_r[i];
            end
        end
    end

    // Polarity bit set means trigger acts on its high level
    assign trig_act   = sync2_r[4] ~^ ctrl_r[`SSC_CTRL_TRIG_POL];

    // Start is the OR of connector start as a low and trigger at the level the polarity bit selects
    assign start_lvl  = (in_en && !branch_sel && !sync2_r[0])
                        || trig_act;
    assign start_prev = (in_en && !branch_sel && !prev_r[0])
                        || (prev_r[4] ~^ ctrl_r[`SSC_CTRL_TRIG_POL]);
    assign start_fall = start_lvl && !start_prev;

    // Disabled inputs never produce an edge, so noise is ignored
    assign stop_fall  = in_en && prev_r[1] && !sync2_r[1];
    assign hold_fall  = in_en && prev_r[2] && !sync2_r[2];
    assign hold_rise  = in_en && !prev_r[2] && sync2_r[2];
    assign event_fall = in_en && seq_mode && prev_r[3] && !sync2_r[3];
    assign shared_low = in_en && branch_sel && !sync2_r[0];

    // ****************************************
    // Tick divider
    // ****************************************
    // One-cycle enable that paces sweep points and step dwell
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_r <= 16'h0000;
        end else if (div_r == 16'(TICK_CYC - 1)) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end
    assign tick = (div_r == 16'(TICK_CYC - 1));

    // ****************************************
    // Sequencer
    // ****************************************
    // Memory read data lag one cycle, so LOAD waits one extra cycle
    assign mem_port.rd_addr = step_r;

    ssc_step_mem u_mem (
        .clk  (clk),
        .port (mem_port)
    );

    // State; stop wins over start, start over hold, hold over event
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= SSC_IDLE;
        end else if (stop_fall) begin
            state_r <= SSC_IDLE;
        end else if (start_fall) begin
            state_r <= seq_mode ? SSC_LOAD : SSC_RUN;
        end else begin
            unique case (state_r)
                SSC_IDLE: state_r <= SSC_IDLE;
                SSC_LOAD: begin
                    if (!wait_r) begin
                        state_r <= SSC_RUN;
                    end
                end
                SSC_RUN: begin
                    if (hold_fall) begin
                        state_r <= SSC_HOLD;
                    end else if (event_fall) begin
                        state_r <= SSC_LOAD;
                    end else if (tick && !seq_mode && pos_r == sweep_end_r) begin
                        state_r <= SSC_IDLE;
                    end else if (tick && seq_mode && dwell_r <= 16'h0001) begin
                        if (!shared_low && step_r == seq_last_r) begin
                            state_r <= SSC_IDLE;
                        end else begin
                            state_r <= SSC_LOAD;
                        end
                    end
                end
                SSC_HOLD: begin
                    if (hold_rise) begin
                        state_r <= SSC_RUN;
                    end
                end
            endcase
        end
    end

    // Wait flag covers the memory read latency; a restart inside LOAD waits again
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= start_fall || (state_r != SSC_LOAD);
        end
    end

    // Step index: first step, destination on branch, else next
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step_r <= 4'h0;
        end else if (stop_fall) begin
            step_r <= step_r;
        end else if (start_fall) begin
            step_r <= 4'h0;
        end else if (state_r == SSC_RUN && seq_mode && !hold_fall) begin
            if (event_fall) begin
                step_r <= mem_port.rd_data.dest;
            end else if (tick && dwell_r <= 16'h0001) begin
                if (shared_low) begin
                    step_r <= mem_port.rd_data.dest;
                end else if (step_r != seq_last_r) begin
                    step_r <= step_r + 4'h1;
                end
            end
        end
    end

    // Dwell counter; held state keeps it so resume picks up mid-step
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dwell_r <= 16'h0000;
        end else if (state_r == SSC_LOAD && !wait_r) begin
            dwell_r <= mem_port.rd_data.dur;
        end else if (state_r == SSC_RUN && seq_mode && tick && dwell_r > 16'h0001) begin
            dwell_r <= dwell_r - 16'h0001;
        end
    end

    // Sweep position; held state keeps it so resume continues there
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pos_r <= 16'h0000;
        end else if (start_fall && !stop_fall && !seq_mode) begin
            pos_r <= 16'h0000;
        end else if (state_r == SSC_RUN && !seq_mode && tick && !hold_fall
                     && !stop_fall && pos_r != sweep_end_r) begin
            pos_r <= pos_r + 16'h0001;
        end
    end

    // Step code follows the loaded step; cleared in sweep mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            code_r <= 4'h0;
        end else if (!seq_mode) begin
            code_r <= 4'h0;
        end else if (state_r == SSC_LOAD && !wait_r) begin
            code_r <= mem_port.rd_data.code;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // All outputs are flops; pins mirror the code register bits
    assign step_code_bit0 = code_r[0];
    assign step_code_bit1 = code_r[1];
    assign step_code_bit2 = code_r[2];
    assign step_code_bit3 = code_r[3];
    assign sweep_pos      = pos_r;
    assign run_state      = state_r;
endmodule

// [tb/ssc_top_checker.sv]
// Purpose: port-level assertions for the sweep/sequence control port
// Assumes: pins and strobes change just after a rising clk edge
// Notes:   keeps its own copy of CTRL, taken from register writes
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_top_checker #(
    parameter int TICK_CYC = 100
) (
    input wire logic            clk,
    input wire logic            rstn,
    input wire logic [7:0]      reg_addr,
    input wire logic [31:0]     reg_wdata,
    input wire logic            reg_wr,
    input wire logic            start_branch_n,
    input wire logic            stop_n,
    input wire logic            hold_resume_n,
    input wire logic            trigger_input_terminal,
    input wire logic [15:0]     sweep_pos,
    input ssc_pkg::ssc_state_t  run_state
);
    import ssc_pkg::*;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [3:0] ctrl_r;
    logic [2:0] quiet_r;
    logic       seq_m, en, br, pol, trig_act;
    // ****************************************
    // Helper state
    // ****************************************
    // Copy of CTRL, effective the cycle after the write like the design
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `SSC_CTRL_RST;
        end else if (reg_wr && reg_addr == `SSC_OFS_CTRL) begin
            ctrl_r <= reg_wdata[3:0];
        end
    end
    assign {pol, br, en, seq_m} = ctrl_r;
    assign trig_act = pol ? trigger_input_terminal : !trigger_input_terminal;
    // Trigger quiet time; saturates so a long idle never wraps
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            quiet_r <= 3'h0;
        end else begin
            quiet_r <= trig_act ? 3'h0 : (quiet_r == 3'h7 ? quiet_r : quiet_r + 3'h1);
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    start_a: assert property (en && !br && stop_n && $fell(start_branch_n)
        |-> ##[1:5] run_state inside {SSC_RUN, SSC_LOAD}) else $error("start edge ignored");
    trig_start_a: assert property (pol && stop_n && $rose(trigger_input_terminal)
        |-> ##[1:5] run_state inside {SSC_RUN, SSC_LOAD}) else $error("trigger ignored");
    stop_a: assert property (en && $fell(stop_n) |-> ##[1:5] run_state == SSC_IDLE)
        else $error("stop edge ignored");
    hold_a: assert property (en && stop_n && $fell(hold_resume_n) && run_state == SSC_RUN
        |-> ##[1:5] run_state == SSC_HOLD) else $error("hold edge ignored");
    resume_a: assert property (en && stop_n && $rose(hold_resume_n) && run_state == SSC_HOLD
        |-> ##[1:5] run_state == SSC_RUN) else $error("resume edge ignored");
    sync_delay_a: assert property ($fell(hold_resume_n) && run_state == SSC_RUN
        |=> run_state != SSC_HOLD) else $error("pin acted on without synchroniser");
    held_still_a: assert property ((run_state == SSC_HOLD) [*2] |-> $stable(sweep_pos))
        else $error("position moved while held");
    pos_step_a: assert property (!seq_m && run_state == SSC_RUN && $past(run_state) == SSC_RUN
        |-> sweep_pos == $past(sweep_pos) || sweep_pos == $past(sweep_pos) + 16'h1
            || sweep_pos == 16'h0) else $error("sweep position jumped");
    disabled_a: assert property (!en && quiet_r == 3'h7 && run_state == SSC_IDLE
        |=> run_state == SSC_IDLE) else $error("disabled pins started a run");
    hold_seen_c: cover property (run_state == SSC_HOLD);
    seq_run_c: cover property (seq_m && run_state == SSC_RUN);
    stop_seen_c: cover property (en && $fell(stop_n));
endmodule

// [tb/ssc_ext_ctl.sv]
// Purpose: outside logic driving the connector control lines
// Assumes: lines are pulled up, so a released line reads high
// Notes:   index 0 start/branch, 1 stop, 2 hold, 3 event, 4 trigger
`timescale 1ns/1ps
module ssc_ext_ctl (
    input  wire logic clk,
    output logic      start_branch_n,
    output logic      stop_n,
    output logic      hold_resume_n,
    output logic      event_branch_n,
    output logic      trigger_input_terminal
);
    logic [4:0] pin_r = 5'h1F;
    // Idle level is the pull-up level on every line
    assign {trigger_input_terminal, event_branch_n, hold_resume_n, stop_n, start_branch_n} = pin_r;
    // Change one line just after an edge and leave it there
    task automatic drive(input int idx, input logic lvl);
        @(posedge clk);
        pin_r[idx] <= lvl;
    endtask
    // Low long enough to pass the synchroniser, then released
    task automatic pulse(input int idx);
        drive(idx, 1'b0);
        repeat (4) @(posedge clk);
        pin_r[idx] <= 1'b1;
    endtask
endmodule

// [tb/tb_ssc_top.sv]
// Purpose: directed bench for the sweep/sequence control port
// Assumes: short tick so a sweep or a step ends within a few dozen cycles
// Notes:   connector lines come from the external controller model
`timescale 1ns/1ps
`include "ssc_consts.svh"
module tb_ssc_top;
    import ssc_pkg::*;
    localparam int          TICK = 2;
    localparam int          P_START = 0, P_STOP = 1, P_HOLD = 2, P_EVT = 3, P_TRIG = 4;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        start_branch_n, stop_n, hold_resume_n, event_branch_n, trig;
    logic [3:0]  code;
    logic [15:0] sweep_pos;
    logic [15:0] p;
    ssc_state_t  run_state;
    int          fail_count = 0;
    int          total_checks = 0;
    // ****************************************
    // Design and outside controller
    // ****************************************
    ssc_top #(.TICK_CYC(TICK)) ssc_top_inst (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .start_branch_n(start_branch_n), .stop_n(stop_n), .hold_resume_n(hold_resume_n),
        .event_branch_n(event_branch_n), .trigger_input_terminal(trig),
        .step_code_bit0(code[0]), .step_code_bit1(code[1]), .step_code_bit2(code[2]),
        .step_code_bit3(code[3]), .sweep_pos(sweep_pos), .run_state(run_state));
    ssc_ext_ctl ssc_ext_ctl_inst (
        .clk(clk), .start_branch_n(start_branch_n), .stop_n(stop_n),
        .hold_resume_n(hold_resume_n), .event_branch_n(event_branch_n),
        .trigger_input_terminal(trig));
    // Free-running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data only stand in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata & m, e);
    endtask
    task automatic step(input logic [3:0] i, c, d, input logic [15:0] t);
        wr(`SSC_OFS_STEP_WR, {4'h0, i, c, d, t});
    endtask
    // Kind 0 waits for a state, kind 1 for the code to leave a value
    task automatic wait_for(input int k, input logic [3:0] v);
        int n;
        n = 0;
        // First look half a cycle on, never in the launching edge's time step
        @(negedge clk);
        while (!(k == 1 ? code !== v : run_state === v[1:0]) && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (n == 500) begin
            fail_count++;
            $display("FAIL %0t wait ran out", $time);
            tally_and_finish();
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdchk(`SSC_OFS_CTRL, ALL, 32'h0);
        rdchk(`SSC_OFS_SWEEP_END, ALL, 32'hFFFF);
        rdchk(`SSC_OFS_SEQ_LAST, ALL, 32'hF);
        rdchk(`SSC_OFS_STEP_WR, ALL, 32'h0);
        rdchk(8'h20, ALL, 32'h0);
        chk(code, 4'h0);
        chk(run_state, SSC_IDLE);
        // Sweep: hold keeps the point, resume carries on, one shot to end
        wr(`SSC_OFS_SWEEP_END, 32'h14);
        wr(`SSC_OFS_CTRL, 32'h2);
        rdchk(`SSC_OFS_CTRL, ALL, 32'h2);
        ssc_ext_ctl_inst.pulse(P_START);
        wait_for(0, SSC_RUN);
        repeat (10) @(negedge clk);
        ssc_ext_ctl_inst.drive(P_HOLD, 1'b0);
        wait_for(0, SSC_HOLD);
        p = sweep_pos;
        repeat (10) @(negedge clk);
        chk(sweep_pos, p);
        ssc_ext_ctl_inst.drive(P_HOLD, 1'b1);
        wait_for(0, SSC_RUN);
        chk(sweep_pos - p <= 16'h1 && p != 16'h0, 1'b1);
        wait_for(0, SSC_IDLE);
        chk(sweep_pos, 16'h14);
        ssc_ext_ctl_inst.pulse(P_START);
        wait_for(0, SSC_RUN);
        chk(sweep_pos <= 16'h1, 1'b1);
        ssc_ext_ctl_inst.pulse(P_STOP);
        wait_for(0, SSC_IDLE);
        chk(sweep_pos < 16'h14, 1'b1);
        // Pins disabled: start ignored, trigger still starts
        wr(`SSC_OFS_CTRL, 32'h0);
        ssc_ext_ctl_inst.pulse(P_START);
        repeat (8) @(negedge clk);
        chk(run_state, SSC_IDLE);
        ssc_ext_ctl_inst.pulse(P_TRIG);
        wait_for(0, SSC_RUN);
        wait_for(0, SSC_IDLE);
        // Sequence with start role: hold, resume, event branch, end
        step(4'h0, 4'h5, 4'h3, 16'h1E);
        step(4'h1, 4'hA, 4'h0, 16'h2);
        step(4'h2, 4'h6, 4'h0, 16'h2);
        step(4'h3, 4'h9, 4'h1, 16'h2);
        wr(`SSC_OFS_SEQ_LAST, 32'h3);
        wr(`SSC_OFS_CTRL, 32'h3);
        ssc_ext_ctl_inst.pulse(P_START);
        wait_for(0, SSC_RUN);
        chk(code, 4'h5);
        ssc_ext_ctl_inst.drive(P_HOLD, 1'b0);
        wait_for(0, SSC_HOLD);
        chk(code, 4'h5);
        ssc_ext_ctl_inst.drive(P_HOLD, 1'b1);
        wait_for(0, SSC_RUN);
        chk(code, 4'h5);
        ssc_ext_ctl_inst.pulse(P_EVT);
        wait_for(1, 4'h5);
        chk(code, 4'h9);
        wait_for(0, SSC_IDLE);
        rdchk(`SSC_OFS_STATUS, 32'hFF, 32'h30);
        // Branch role: shared line held low never starts, branches at step end
        wr(`SSC_OFS_CTRL, 32'h7);
        ssc_ext_ctl_inst.drive(P_START, 1'b0);
        repeat (8) @(negedge clk);
        chk(run_state, SSC_IDLE);
        ssc_ext_ctl_inst.pulse(P_TRIG);
        wait_for(0, SSC_RUN);
        chk(code, 4'h5);
        wait_for(1, 4'h5);
        chk(code, 4'h9);
        wait_for(1, 4'h9);
        chk(code, 4'hA);
        ssc_ext_ctl_inst.pulse(P_STOP);
        wait_for(0, SSC_IDLE);
        ssc_ext_ctl_inst.drive(P_START, 1'b1);
        // Trigger active high: falling edge idle, rising edge starts
        wr(`SSC_OFS_CTRL, 32'hA);
        ssc_ext_ctl_inst.drive(P_TRIG, 1'b0);
        repeat (8) @(negedge clk);
        chk(run_state, SSC_IDLE);
        ssc_ext_ctl_inst.drive(P_TRIG, 1'b1);
        wait_for(0, SSC_RUN);
        // Sweep mode: event line ignored, step code forced to zero
        ssc_ext_ctl_inst.pulse(P_EVT);
        repeat (4) @(negedge clk);
        chk(run_state, SSC_RUN);
        chk(code, 4'h0);
        ssc_ext_ctl_inst.pulse(P_STOP);
        wait_for(0, SSC_IDLE);
        tally_and_finish();
    end
endmodule
bind ssc_top ssc_top_checker #(.TICK_CYC(TICK_CYC)) ssc_top_checker_inst (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .start_branch_n(start_branch_n), .stop_n(stop_n), .hold_resume_n(hold_resume_n),
    .trigger_input_terminal(trigger_input_terminal), .sweep_pos(sweep_pos),
    .run_state(run_state));
